// *** flash_host_ctrl.sv ***
// AXI4-Lite controlled host that issues command sequences and polls a parallel NOR flash
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output flash_pins_t flash_out,
  input wire logic [7:0] flash_dq_in,
  input wire logic operation_done_pin
);

  // Register-bus state
  logic [18:0] target_reg; // Program, sector or read address
  logic [18:0] target_next;
  logic [7:0] value_reg; // Byte to program
  logic [7:0] value_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_fire; // Address and data taken together
  logic cmd_strobe; // One-cycle command write
  logic [2:0] cmd_op;

  // Sequencer state
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [2:0] op_reg;
  logic [2:0] op_next;
  logic [2:0] step_reg; // Index of the command cycle in flight
  logic [2:0] step_next;
  logic [3:0] cnt_reg; // Strobe phase timer
  logic [3:0] cnt_next;
  logic poll_reg; // Reading status bits rather than data
  logic poll_next;
  logic first_reg; // First of a pair of status reads
  logic first_next;
  logic [7:0] prev_reg; // Previous status read
  logic [7:0] prev_next;
  logic [7:0] data_reg; // Last byte read back
  logic [7:0] data_next;
  logic done_reg;
  logic done_next;
  logic fail_reg;
  logic fail_next;
  logic susp_req_reg; // Suspend asked for while a sector erase is polled
  logic susp_req_next;
  logic suspended_reg;
  logic suspended_next;
  flash_pins_t pins_reg;
  flash_pins_t pins_next;

  logic [8:0] sync_q; // Synchronised data pins and ready pin
  logic busy;
  bus_step_t cur_step;

  // Pins from the flash cross three stages before use
  flash_pin_sync #(
    .WIDTH(9)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin_in({operation_done_pin, flash_dq_in}),
    .pin_sync(sync_q)
  );

  // Lane merge so partial writes keep untouched bytes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // Address and data of each command cycle; unlock cycles carry zeros above A11
  function automatic bus_step_t step_of(input logic [2:0] op, input logic [2:0] idx,
                                        input logic [18:0] tgt, input logic [7:0] val);
    bus_step_t s;
    s = '{addr: UNLOCK_ADDR_A, data: CODE_UNLOCK_A, last: 1'b0};
    if (idx == 3'h1 || idx == 3'h4) begin
      s.addr = UNLOCK_ADDR_B;
      s.data = CODE_UNLOCK_B;
    end
    case (op)
      OP_PROGRAM: begin
        if (idx == 3'h2) begin
          s.data = CODE_PROGRAM;
        end else if (idx == 3'h3) begin
          s = '{addr: tgt, data: val, last: 1'b1};
        end
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        if (idx == 3'h2) begin
          s.data = CODE_ERASE_SETUP;
        end else if (idx == 3'h5 && op == OP_CHIP_ERASE) begin
          s = '{addr: UNLOCK_ADDR_A, data: CODE_CHIP_ERASE, last: 1'b1};
        end else if (idx == 3'h5) begin
          s = '{addr: tgt, data: CODE_SECTOR_ERASE, last: 1'b1};
        end
      end
      OP_IDENT: begin
        if (idx == 3'h2) begin
          s = '{addr: UNLOCK_ADDR_A, data: CODE_IDENT, last: 1'b1};
        end
      end
      OP_SUSPEND: s = '{addr: tgt, data: CODE_SUSPEND, last: 1'b1};
      OP_RESUME: s = '{addr: tgt, data: CODE_RESUME, last: 1'b1};
      default: s = '{addr: tgt, data: CODE_RESET, last: 1'b1};
    endcase
    return s;
  endfunction : step_of

  assign busy = (state_reg != S_IDLE);
  assign cur_step = step_of(op_reg, step_reg, target_reg, value_reg);

  // Handshakes: write address and data are taken together, one answer outstanding
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !rvalid_reg;
  assign cmd_strobe = wr_fire && (s_axi_awaddr == OFS_CMD) && s_axi_wstrb[0];
  assign cmd_op = s_axi_wdata[2:0];

  // Register bus next values
  always_comb begin
    target_next = target_reg;
    value_next = value_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      case (s_axi_awaddr)
        OFS_CMD: ; // Taken by the sequencer
        OFS_TARGET: target_next = 19'(merge({13'h0, target_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_VALUE: value_next = 8'(merge({24'h0, value_reg}, s_axi_wdata, s_axi_wstrb));
        OFS_STATUS: ; // Read only, writes dropped
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = 32'h0;
      case (s_axi_araddr)
        OFS_CMD: rdata_next = {29'h0, op_reg};
        OFS_TARGET: rdata_next = {13'h0, target_reg};
        OFS_VALUE: rdata_next = {24'h0, value_reg};
        OFS_STATUS: begin
          rdata_next[ST_BUSY] = busy;
          rdata_next[ST_DONE] = done_reg;
          rdata_next[ST_FAIL] = fail_reg;
          rdata_next[ST_READY_PIN] = sync_q[8];
          rdata_next[ST_SUSPENDED] = suspended_reg;
          rdata_next[ST_DATA_LO +: 8] = data_reg;
        end
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // Register bus flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      target_reg <= 19'h0;
      value_reg <= 8'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else if (clk_en) begin
      target_reg <= target_next;
      value_reg <= value_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = RESP_OKAY;

  // Sequencer next values: write cycles, read cycles and status polling
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    step_next = step_reg;
    cnt_next = cnt_reg;
    poll_next = poll_reg;
    first_next = first_reg;
    prev_next = prev_reg;
    data_next = data_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    susp_req_next = susp_req_reg;
    suspended_next = suspended_reg;
    pins_next = '{addr: pins_reg.addr, dq_out: pins_reg.dq_out, dq_oe: 1'b0,
                  ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    // Only a suspend is taken while a sector erase is polled; other commands written while busy are dropped
    if (cmd_strobe && busy && cmd_op == OP_SUSPEND && op_reg == OP_SECTOR_ERASE && poll_reg) begin
      susp_req_next = 1'b1;
    end
    case (state_reg)
      S_IDLE: begin
        // Flash decodes every command again once idle
        if (cmd_strobe) begin
          op_next = cmd_op;
          step_next = 3'h0;
          cnt_next = 4'h0;
          done_next = 1'b0;
          fail_next = 1'b0;
          poll_next = 1'b0;
          if (cmd_op == OP_READ) begin
            state_next = S_RD_LOW;
          end else begin
            state_next = S_WR_LOW;
          end
        end
      end
      S_WR_LOW: begin
        // Address falls with the strobe, data is held past its rising edge
        pins_next = '{addr: cur_step.addr, dq_out: cur_step.data, dq_oe: 1'b1,
                      ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == WE_LOW_CYC - 4'h1) begin
          cnt_next = 4'h0;
          state_next = S_WR_HIGH;
        end
      end
      S_WR_HIGH: begin
        // Data still driven for one clock of hold after the strobe rises
        pins_next.dq_oe = (cnt_reg == 4'h0);
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == WE_HIGH_CYC - 4'h1) begin
          cnt_next = 4'h0;
          if (!cur_step.last) begin
            step_next = step_reg + 3'h1;
            state_next = S_WR_LOW;
          end else if (op_reg == OP_IDENT) begin
            state_next = S_RD_LOW; // Identifier or protection byte at the target
          end else if (op_reg == OP_PROGRAM || op_reg == OP_CHIP_ERASE ||
                       op_reg == OP_SECTOR_ERASE || op_reg == OP_RESUME) begin
            poll_next = 1'b1; // The flash times the operation on its own
            first_next = 1'b1;
            suspended_next = 1'b0;
            state_next = S_RD_LOW;
          end else begin
            suspended_next = (op_reg == OP_SUSPEND); // Flash now serves array reads
            done_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      end
      S_RD_LOW: begin
        // Output enable only with the data pins released
        pins_next = '{addr: poll_reg ? pins_reg.addr : target_reg, dq_out: pins_reg.dq_out,
                      dq_oe: 1'b0, ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
        cnt_next = cnt_reg + 4'h1;
        if (cnt_reg == READ_CYC - 4'h1) begin
          cnt_next = 4'h0;
          state_next = S_RD_HIGH;
        end
      end
      S_RD_HIGH: begin
        state_next = S_IDLE;
        done_next = 1'b1;
        data_next = sync_q[7:0];
        if (poll_reg && first_reg) begin
          prev_next = sync_q[7:0];
          first_next = 1'b0;
          done_next = 1'b0;
          state_next = S_RD_LOW;
        end else if (poll_reg && prev_reg[TOGGLE_FLAG_BIT] == sync_q[TOGGLE_FLAG_BIT]) begin
          poll_next = 1'b0; // Toggle stopped over two reads: finished
        end else if (poll_reg && sync_q[TIMEOUT_FLAG_BIT]) begin
          poll_next = 1'b0; // Timed out: abort with a reset write
          fail_next = 1'b1;
          done_next = 1'b0;
          op_next = OP_RESET;
          step_next = 3'h0;
          state_next = S_WR_LOW;
        end else if (poll_reg && susp_req_reg) begin
          poll_next = 1'b0; // Erase still running, suspend it now
          susp_req_next = 1'b0;
          done_next = 1'b0;
          op_next = OP_SUSPEND;
          step_next = 3'h0;
          state_next = S_WR_LOW;
        end else if (poll_reg) begin
          prev_next = sync_q[7:0];
          done_next = 1'b0;
          state_next = S_RD_LOW;
        end else if (op_reg == OP_IDENT) begin
          done_next = 1'b0; // Leave identifier mode with a reset write
          op_next = OP_RESET;
          step_next = 3'h0;
          state_next = S_WR_LOW;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  // Sequencer flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
      op_reg <= OP_READ;
      step_reg <= 3'h0;
      cnt_reg <= 4'h0;
      poll_reg <= 1'b0;
      first_reg <= 1'b0;
      prev_reg <= 8'h0;
      data_reg <= 8'h0;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      susp_req_reg <= 1'b0;
      suspended_reg <= 1'b0;
      pins_reg <= '{addr: 19'h0, dq_out: 8'h0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
    end else if (clk_en) begin
      state_reg <= state_next;
      op_reg <= op_next;
      step_reg <= step_next;
      cnt_reg <= cnt_next;
      poll_reg <= poll_next;
      first_reg <= first_next;
      prev_reg <= prev_next;
      data_reg <= data_next;
      done_reg <= done_next;
      fail_reg <= fail_next;
      susp_req_reg <= susp_req_next;
      suspended_reg <= suspended_next;
      pins_reg <= pins_next;
    end
  end

  assign flash_out = pins_reg;

endmodule : flash_host_ctrl

// *** flash_host_pkg.sv ***
// Shared constants, pin bundle and state types for the parallel flash host controller
package flash_host_pkg;

  // Register byte offsets on the AXI4-Lite side
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_VALUE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_READY_PIN = 3;
  localparam int ST_SUSPENDED = 4;
  localparam int ST_DATA_LO = 8;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes written to the command register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h2;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
  localparam logic [2:0] OP_SUSPEND = 3'h4;
  localparam logic [2:0] OP_RESUME = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  localparam logic [2:0] OP_IDENT = 3'h7;

  // Command cycle addresses and codes of the flash
  localparam logic [18:0] UNLOCK_ADDR_A = 19'h00555;
  localparam logic [18:0] UNLOCK_ADDR_B = 19'h002aa;
  localparam logic [7:0] CODE_UNLOCK_A = 8'haa;
  localparam logic [7:0] CODE_UNLOCK_B = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'ha0;
  localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CODE_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] CODE_RESUME = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'hf0;

  // Status bits the flash returns while busy
  localparam int TOGGLE_FLAG_BIT = 6;
  localparam int TIMEOUT_FLAG_BIT = 5;

  // Bus cycle timing, least times rounded up to whole clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int WE_LOW_NS = 50;
  localparam int WE_HIGH_NS = 30;
  localparam int READ_ACCESS_NS = 90;
  localparam int SYNC_LATENCY = 3;
  localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WE_HIGH_CYC = 4'((WE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_CYC = 4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_LATENCY);

  // Outgoing flash pins
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
  } flash_pins_t;

  // One command bus cycle
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0] data;
    logic last;
  } bus_step_t;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_WR_LOW = 3'b001,
    S_WR_HIGH = 3'b010,
    S_RD_LOW = 3'b011,
    S_RD_HIGH = 3'b100
  } seq_state_t;

endpackage : flash_host_pkg

// *** flash_pin_sync.sv ***
// Three-stage input synchroniser that passes a value once the last two stages agree
`timescale 1ns/1ns
module flash_pin_sync
  import flash_host_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] st1_reg; // First stage, read only by the second
  logic [WIDTH-1:0] st2_reg;
  logic [WIDTH-1:0] st3_reg;
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;

  // Accept a change only when stages two and three agree, filtering one-clock glitches
  always_comb begin
    out_next = out_reg;
    if (st2_reg == st3_reg) begin
      out_next = st3_reg;
    end
  end

  // Shift chain, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st1_reg <= '0;
      st2_reg <= '0;
      st3_reg <= '0;
      out_reg <= '0;
    end else if (clk_en) begin
      st1_reg <= pin_in;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
      out_reg <= out_next;
    end
  end

  assign pin_sync = out_reg;

endmodule : flash_pin_sync

// *** flash_host_props.sv ***
// Port-level checks of the flash host controller
`timescale 1ns/1ns
module flash_host_props
  import flash_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire flash_pins_t flash_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Strobes are parked inactive as reset lets go
  a_reset_idle: assert property ($fell(reset) |-> flash_out.ce_n && flash_out.we_n && flash_out.oe_n && !flash_out.dq_oe)
    else $error("flash pins not idle after reset");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && clk_en |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid && s_axi_rresp == RESP_OKAY)
    else $error("read response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // A write strobe is five clocks long with data driven throughout
  a_we_pulse: assert property ($fell(flash_out.we_n) |->
    (!flash_out.we_n && !flash_out.ce_n && flash_out.dq_oe)[*5] ##1 flash_out.we_n) else $error("bad write strobe");
  // Address and data must not move under a low strobe
  a_we_hold: assert property (!flash_out.we_n && $past(!flash_out.we_n) |->
    $stable(flash_out.addr) && $stable(flash_out.dq_out)) else $error("write cycle changed");
  // No drive while the flash drives
  a_no_fight: assert property (!flash_out.oe_n |-> !flash_out.dq_oe && flash_out.we_n && !flash_out.ce_n)
    else $error("bus contention");
  a_rd_pulse: assert property ($fell(flash_out.oe_n) |-> (!flash_out.oe_n && !flash_out.ce_n)[*8])
    else $error("read strobe short");
  c_write: cover property ($fell(flash_out.we_n));
  c_read: cover property ($fell(flash_out.oe_n));
  c_fail: cover property (s_axi_rvalid && s_axi_rdata[ST_FAIL]);
endmodule : flash_host_props

bind flash_host_ctrl flash_host_props u_flash_host_props (.*);

// *** flash_dev_model.sv ***
// Behavioural model of the byte-wide flash on the far side of the controller
`timescale 1ns/1ns
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3c, // Arbitrary value
  parameter logic [5:0] PROT_SEL = 6'h3d, // Sector select of the one protected sector
  parameter int PROG_NS = 1500,
  parameter int ERASE_NS = 4000
) (
  input wire flash_pins_t pins,
  input wire logic fail_next,
  output logic [7:0] q,
  output logic ready_pin
);
  logic [7:0] mem [int]; // Sparse array, absent bytes read erased
  logic [18:0] lat_addr = 19'h0; // Address caught as the strobe opens
  logic [18:0] er_base = 19'h0; // Sector under erase
  logic [7:0] q_hold = 8'h00; // Value handed out by the current read
  logic busy = 1'b0, tmo = 1'b0, susp = 1'b0, ident = 1'b0, tog = 1'b0, sect_er = 1'b0, armed = 1'b0;
  int step = 0;
  int remain = 0;
  int kind = 0; // 0 program, 1 chip erase, 2 sector erase
  wire logic wr_n = pins.we_n | pins.ce_n;
  wire logic rd = !pins.ce_n && !pins.oe_n && pins.we_n;

  function automatic logic [7:0] rd_byte(input logic [18:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
  endfunction : rd_byte

  task automatic start(input int ns, input int k);
    busy = 1'b1;
    remain = ns;
    kind = k;
    sect_er = (k == 2);
    armed = (k != 0) && fail_next;
    er_base = lat_addr;
  endtask : start

  always @(negedge wr_n) lat_addr = pins.addr;
  // Command decoder, run as the data is latched
  always @(posedge wr_n) begin : decode
    logic [7:0] d;
    logic u5, u2;
    d = pins.dq_out;
    u5 = lat_addr[11:0] == 12'h555;
    u2 = lat_addr[11:0] == 12'h2aa;
    if (busy) begin
      // Program ignores everything; sector erase honours suspend, a timed-out erase honours reset only
      if (sect_er && !tmo && d == CODE_SUSPEND) begin
        susp = 1'b1;
        busy = 1'b0;
      end else if (tmo && d == CODE_RESET) begin
        busy = 1'b0;
        tmo = 1'b0;
      end
    end else if (d == CODE_RESET) begin
      step = 0;
      ident = 1'b0;
    end else if (susp && step == 0 && d == CODE_RESUME) begin
      susp = 1'b0;
      busy = 1'b1;
    end else begin
      case (step)
        0, 3: step = (u5 && d == CODE_UNLOCK_A) ? step + 1 : 0;
        1, 4: step = (u2 && d == CODE_UNLOCK_B) ? step + 1 : 0;
        2: begin
          ident = u5 && d == CODE_IDENT;
          step = (u5 && d == CODE_PROGRAM) ? 10 : (u5 && d == CODE_ERASE_SETUP) ? 3 : 0;
        end
        5: begin
          if (u5 && d == CODE_CHIP_ERASE) start(ERASE_NS, 1);
          else if (d == CODE_SECTOR_ERASE) start(ERASE_NS, 2);
          step = 0;
        end
        10: begin
          mem[int'(lat_addr)] = rd_byte(lat_addr) & d;
          start(PROG_NS, 0);
          step = 0;
        end
        default: step = 0;
      endcase
    end
  end

  // Self-timed run: the host only polls, a failing run sets the timeout flag
  always #10 begin
    if (busy && !tmo) begin
      if (remain > 0) remain -= 10;
      else if (armed) tmo = 1'b1;
      else begin
        if (kind == 1) mem.delete();
        else if (kind == 2) foreach (mem[k]) if (k[18:16] == er_base[18:16]) mem[k] = 8'hff;
        busy = 1'b0;
        sect_er = 1'b0;
      end
    end
  end

  // Value chosen as the read opens; status toggles on each read while busy
  always @(posedge rd) begin
    if (busy || tmo) begin
      tog = ~tog;
      q_hold = {1'b0, tog, tmo, 5'h00};
    end else if (ident) begin
      case (pins.addr[1:0])
        2'h0: q_hold = MAKER_CODE;
        2'h1: q_hold = PART_CODE;
        2'h2: q_hold = {7'h00, pins.addr[18:13] == PROT_SEL};
        default: q_hold = 8'h00;
      endcase
    end else q_hold = rd_byte(pins.addr);
  end
  // Released pins show the inverse of the last value, never a held copy
  assign q = rd ? q_hold : ~q_hold;
  assign ready_pin = !busy;
endmodule : flash_dev_model

// *** flash_host_ctrl_tb_top.sv ***
// Self-checking bench: register accesses drive the controller against the flash model
`timescale 1ns/1ns
module flash_host_ctrl_tb_top;
  import flash_host_pkg::*;
  localparam logic [18:0] ID_ADDR [4] = '{19'h7fffc, 19'h00005, 19'h7a002, 19'h12002};
  localparam logic [7:0] ID_VAL [4] = '{8'h5a, 8'h3c, 8'h01, 8'h00}; // Model's arbitrary codes
  logic sys_clk = 1'b0, reset = 1'b1;
  logic clk_en = 1'b1; // Held high: freezing is not exercised
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf; // Whole words only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, operation_done_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] flash_dq_in, dev_q;
  logic fail_next = 1'b0; // Makes the next erase overrun its time limit
  flash_pins_t flash_out;
  int n_mismatch = 0, checks_done = 0;

  // Shared data pins
  assign flash_dq_in = flash_out.dq_oe ? flash_out.dq_out : dev_q;
  initial forever #5 sys_clk = ~sys_clk;

  flash_host_ctrl u_flash_host_ctrl (.*);
  flash_dev_model u_flash_dev_model (.pins(flash_out), .fail_next, .q(dev_q), .ready_pin(operation_done_pin));

  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic give_up();
    n_mismatch++;
    test_done();
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  // Address and data offered together, each held until its ready is seen
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n = 0;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    do @(posedge sys_clk); while (!(s_axi_awready && s_axi_wready) && ++n < 100);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(posedge sys_clk); while (!s_axi_bvalid && ++n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) give_up();
  endtask : axi_wr
  // Ready is sampled only at an edge after the request is up
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge sys_clk); while (!s_axi_arready && ++n < 100);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid && ++n < 100);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (n >= 100) give_up();
  endtask : axi_rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk_resp(r, RESP_OKAY);
  endtask : wr
  // Polls status until the flash sequence has ended
  task automatic wait_idle(output logic [31:0] st);
    int n = 0;
    do axi_rd(OFS_STATUS, st); while (st[ST_BUSY] !== 1'b0 && ++n < 600);
    if (n >= 600) give_up();
  endtask : wait_idle
  task automatic run_op(input logic [2:0] op, input logic [18:0] tgt, input logic [7:0] val, output logic [31:0] st);
    wr(OFS_TARGET, {13'h0, tgt});
    wr(OFS_VALUE, {24'h0, val});
    wr(OFS_CMD, {29'h0, op});
    wait_idle(st);
  endtask : run_op

  initial begin
    logic [31:0] st, d;
    logic [1:0] r;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    // Unmapped offset: write refused, read gives zero
    axi_wr(8'h10, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    axi_rd(8'h10, d);
    chk(d, 32'h0);
    wr(OFS_TARGET, 32'hffff_ffff);
    axi_rd(OFS_TARGET, d);
    chk(d, 32'h0007_ffff);
    // Ready pin has crossed the synchroniser by now; nothing else set
    axi_rd(OFS_STATUS, st);
    chk(st & 32'h1f, 32'h08);
    // Identifier mode: maker, part, one protected and one open sector
    for (int i = 0; i < 4; i++) begin
      run_op(OP_IDENT, ID_ADDR[i], 8'h00, st);
      chk({st[15:8], st[2:0]}, {ID_VAL[i], 3'b010});
    end
    // Program then read back through the array
    run_op(OP_PROGRAM, 19'h12345, 8'ha5, st);
    chk(st[2:0], 3'b010);
    run_op(OP_READ, 19'h12345, 8'h00, st);
    chk(st[15:8], 8'ha5);
    // Sector erase suspended once polling runs, data still readable
    wr(OFS_TARGET, 32'h0001_0000);
    wr(OFS_CMD, {29'h0, OP_SECTOR_ERASE});
    repeat (80) @(posedge sys_clk); // Six write cycles of eight clocks come first
    wr(OFS_CMD, {29'h0, OP_SUSPEND});
    wait_idle(st);
    chk({st[ST_SUSPENDED], st[ST_FAIL]}, 2'b10);
    run_op(OP_READ, 19'h12345, 8'h00, st);
    chk(st[15:8], 8'ha5);
    wr(OFS_CMD, {29'h0, OP_RESUME});
    wait_idle(st);
    run_op(OP_READ, 19'h12345, 8'h00, st);
    chk(st[15:8], 8'hff);
    // Chip erase overruns its limit, controller aborts it
    fail_next <= 1'b1;
    run_op(OP_CHIP_ERASE, 19'h0, 8'h00, st);
    chk({st[ST_FAIL], st[ST_BUSY]}, 2'b10);
    fail_next <= 1'b0;
    run_op(OP_CHIP_ERASE, 19'h0, 8'h00, st);
    chk(st[2:0], 3'b010);
    run_op(OP_RESET, 19'h0, 8'h00, st);
    chk(st[2:0], 3'b010);
    test_done();
  end
endmodule : flash_host_ctrl_tb_top
